//--- hdl/pepfc_top.v
`timescale 1ns/10ps
`include "pepfc_map.vh"
module pepfc_top (
  input wire clk_sys_in, // system clock
  input wire rst_in, // async reset, high
  input wire [2:0] mode_in, // operating mode code
  input wire e_stretch_ctrl_in, // E stretch control
  input wire debug_tagging_in, // debug tagging active
  input wire e_clock_in, // internal E clock
  input wire e_clock_pin_in, // E pin level
  input wire [1:0] pipe_status_in, // queue status
  input wire clock_test_in, // clock module test signal
  input wire low_byte_strobe_in, // bus low strobe
  input wire bus_read_in, // bus direction, high read
  input wire data_bus_enable_n_in, // data bus enable, low
  input wire cal_ref_in, // calibration reference
  input wire [7:0] pe_gpio_out_in, // gpio data for port E
  input wire [7:0] pe_gpio_dir_in, // gpio direction, 1 out
  input wire [7:0] pe_pin_in, // port E pin levels
  input wire [4:0] port_dir_any_in, // any output per port
  input wire [31:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // response ready
  input wire [31:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read ready
  output reg [7:0] pe_pin_out, // port E drive level
  output reg [7:0] pe_pin_oe_out, // port E enable, high drives
  output reg [7:0] pe_pull_out, // port E pull-up on
  output reg e_clock_is_input_out, // E pin is input
  output reg low_byte_tag_out, // tag pulse
  output reg [4:0] pull_active_out, // A,B,E,G,H pulls
  output reg [4:0] low_drive_out // A,B,E,G,H reduced drive
);
  // ==========================================
  // mode decode
  function is_special;
    input [2:0] m;
    begin
      is_special = m[2];
    end
  endfunction
  function is_single;
    input [2:0] m;
    begin
      is_single = (m == `PEPFC_M_NSC) || (m == `PEPFC_M_SSC);
    end
  endfunction
  // one-hot register select; upper address bits must be zero
  // so that aliases above the block answer with an error
  function [3:0] reg_dec;
    input [31:0] a;
    begin
      reg_dec = 4'h0;
      if (a[31:4] == 28'h0) begin
        case (a[3:0])
          `PEPFC_ADDR_ASGN: begin
            reg_dec = 4'h1;
          end
          `PEPFC_ADDR_PULL: begin
            reg_dec = 4'h2;
          end
          `PEPFC_ADDR_RDRV: begin
            reg_dec = 4'h4;
          end
          `PEPFC_ADDR_CTRL: begin
            reg_dec = 4'h8;
          end
          default: begin
            reg_dec = 4'h0;
          end
        endcase
      end
    end
  endfunction
  wire sc = is_single(mode_in);
  wire per = (mode_in == `PEPFC_M_PER);
  wire exp = !sc && !per;
  wire spec = is_special(mode_in);
  wire nexn = (mode_in == `PEPFC_M_NEXN);
  wire sexp = (mode_in == `PEPFC_M_SEXN) || (mode_in == `PEPFC_M_SEXW);
  reg [7:0] port_e_pin_assignment_q;
  reg [7:0] pull_q;
  reg [7:0] rdrv_q;
  reg port_e_pin_assignment_wr_q; // first write seen
  reg rdrv_wr_q;
  reg [7:0] port_e_pin_assignment_rst;
  reg rst_load_q;
  always @* begin
    case (mode_in)
      `PEPFC_M_NSC: port_e_pin_assignment_rst = `PEPFC_RST_NSC;
      `PEPFC_M_PER: port_e_pin_assignment_rst = `PEPFC_RST_PER;
      `PEPFC_M_SSC: port_e_pin_assignment_rst = `PEPFC_RST_SSC;
      `PEPFC_M_SEXN, `PEPFC_M_SEXW: port_e_pin_assignment_rst = `PEPFC_RST_SEX;
      default: port_e_pin_assignment_rst = `PEPFC_RST_NEX; // R19
    endcase
  end
  // ==========================================
  // bus slave
  reg [31:0] aw_q;
  reg aw_have_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg w_have_q;
  wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [3:0] wsel = reg_dec(aw_q);
  wire [3:0] rsel = reg_dec(s_axi_araddr);
  wire hidden_w = per && !wsel[3]; // R13
  wire wmap = |wsel[2:0];
  wire wr_ok = wr_go && wmap && !hidden_w && ws_q[0];
  // protected mask: write-once/skip-first group
  wire [7:0] prot = 8'hAD;
  wire port_e_pin_assignment_allow = spec ? port_e_pin_assignment_wr_q : !port_e_pin_assignment_wr_q; // R2 R20
  wire neck_allow = (mode_in == `PEPFC_M_SSC) ||
    ((mode_in == `PEPFC_M_NSC) && !port_e_pin_assignment_wr_q); // R3
  wire cgmt_allow = spec && port_e_pin_assignment_wr_q;
  reg [7:0] port_e_pin_assignment_d;
  always @* begin
    port_e_pin_assignment_d = port_e_pin_assignment_q;
    port_e_pin_assignment_d[`PEPFC_B_CALEN] = wd_q[`PEPFC_B_CALEN]; // R10
    if (port_e_pin_assignment_allow) begin
      port_e_pin_assignment_d = (port_e_pin_assignment_d & ~prot) | (wd_q[7:0] & prot); // R2
    end
    if (neck_allow) begin
      port_e_pin_assignment_d[`PEPFC_B_NECK] = wd_q[`PEPFC_B_NECK]; // R3
    end
    if (cgmt_allow) begin
      port_e_pin_assignment_d[`PEPFC_B_CGMT] = wd_q[`PEPFC_B_CGMT];
    end
  end
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 32'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PEPFC_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PEPFC_RESP_OK;
      port_e_pin_assignment_q <= `PEPFC_RST_NEX;
      pull_q <= `PEPFC_RST_PULL;
      rdrv_q <= `PEPFC_RST_RDRV;
      port_e_pin_assignment_wr_q <= 1'b0;
      rdrv_wr_q <= 1'b0;
      rst_load_q <= 1'b1;
    end else begin
      // mode straps caught first cycle after release
      rst_load_q <= 1'b0;
      if (rst_load_q) begin
        port_e_pin_assignment_q <= port_e_pin_assignment_rst;
      end
      s_axi_awready <= !aw_have_q && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_have_q && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go && !rst_load_q) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wmap && !hidden_w) ? `PEPFC_RESP_OK : `PEPFC_RESP_ERR;
        if (wr_ok && wsel[0]) begin
          port_e_pin_assignment_q <= port_e_pin_assignment_d;
          port_e_pin_assignment_wr_q <= 1'b1; // R20
        end
        if (wr_ok && wsel[1]) begin
          pull_q <= wd_q[7:0];
        end
        if (wr_ok && wsel[2]) begin
          if (spec ? rdrv_wr_q : !rdrv_wr_q) begin
            rdrv_q <= wd_q[7:0]; // R2
          end
          rdrv_wr_q <= 1'b1; // R20
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `PEPFC_RESP_OK;
        s_axi_rdata <= 32'h0;
        if (rsel[3]) begin
          s_axi_rdata <= {26'h0, port_e_pin_assignment_wr_q, rdrv_wr_q, 1'b0, mode_in};
        end else if (rsel[2:0] == 3'h0) begin
          s_axi_rresp <= `PEPFC_RESP_ERR;
        end else if (per) begin
          // hidden registers in peripheral mode still answer, with an error
          s_axi_rresp <= `PEPFC_RESP_ERR; // R13
        end else if (rsel[0]) begin
          s_axi_rdata <= {24'h0, port_e_pin_assignment_q};
        end else if (rsel[1]) begin
          s_axi_rdata <= {24'h0, pull_q};
        end else begin
          s_axi_rdata <= {24'h0, rdrv_q};
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ==========================================
  // pin function mux
  localparam [7:0] pin_lvl_rst = `PEPFC_RST_PIN_LVL;
  localparam [7:0] pin_oe_rst = `PEPFC_RST_PIN_OE;
  localparam [7:0] pull_mask = `PEPFC_PULL_E_MASK;
  reg [7:0] fo;
  reg [7:0] fe;
  reg [7:0] alt;
  always @* begin
    alt = 8'h00;
    fo = pe_gpio_out_in;
    fe = pe_gpio_dir_in & 8'hFC; // PE1:0 input only
    if (port_e_pin_assignment_q[`PEPFC_B_PIPE] && exp) begin
      alt[6:5] = 2'b11; // R1
      fo[6:5] = pipe_status_in;
    end else if (port_e_pin_assignment_q[`PEPFC_B_CGMT] && (per || sexp)) begin
      alt[6] = 1'b1; // R1
      fo[6] = clock_test_in;
    end
    if (!port_e_pin_assignment_q[`PEPFC_B_NECK] && !per && !(sc && e_stretch_ctrl_in)) begin
      alt[4] = 1'b1; // R5
      fo[4] = e_clock_in;
    end
    if (nexn) begin
      alt[3] = 1'b1; // R7
      fo[3] = 1'b1;
    end else if (port_e_pin_assignment_q[`PEPFC_B_LSTR] && exp) begin
      alt[3] = 1'b1; // R6
      fo[3] = low_byte_strobe_in;
    end
    if (port_e_pin_assignment_q[`PEPFC_B_RWEN] && exp) begin
      alt[2] = 1'b1; // R9
      fo[2] = bus_read_in;
    end
    if (exp && !port_e_pin_assignment_q[`PEPFC_B_DENDIS]) begin
      alt[7] = 1'b1; // R11 R18
      fo[7] = port_e_pin_assignment_q[`PEPFC_B_SEL] ? !e_clock_in : data_bus_enable_n_in;
    end else if (port_e_pin_assignment_q[`PEPFC_B_CALEN]) begin
      alt[7] = 1'b1; // R10 R12
      fo[7] = cal_ref_in;
    end
    fe = fe & ~alt;
    fe = fe | alt;
  end
  reg e_prev_q;
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      e_clock_is_input_out <= 1'b0;
      low_byte_tag_out <= 1'b0;
      pull_active_out <= 5'h00;
      low_drive_out <= 5'h00;
      e_prev_q <= 1'b0;
    end else begin
      e_clock_is_input_out <= per; // R4
      pull_active_out[0] <= pull_q[`PEPFC_B_PA] && sc && !port_dir_any_in[0]; // R15
      pull_active_out[1] <= pull_q[`PEPFC_B_PB] && sc && !port_dir_any_in[1]; // R15
      pull_active_out[2] <= pull_q[`PEPFC_B_PE] && (|(pull_mask & ~fe)); // R14
      pull_active_out[3] <= pull_q[`PEPFC_B_PG] && !port_dir_any_in[3]; // R16
      pull_active_out[4] <= pull_q[`PEPFC_B_PH] && !port_dir_any_in[4]; // R16
      low_drive_out <= {rdrv_q[7], rdrv_q[6], rdrv_q[4], rdrv_q[1], rdrv_q[0]}; // R17
      e_prev_q <= e_clock_in;
      // R8: low on PE3 at E falling edge tags low byte
      low_byte_tag_out <= e_prev_q && !e_clock_in && sexp &&
        port_e_pin_assignment_q[`PEPFC_B_LSTR] && debug_tagging_in && !pe_pin_in[3];
    end
  end
  // ==========================================
  // per-pin output flops
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          // reset value cannot follow the mode, so PE3 is a high output
          // through every reset; narrow expanded boot needs it that way
          pe_pin_out[gi] <= pin_lvl_rst[gi]; // R7
          pe_pin_oe_out[gi] <= pin_oe_rst[gi]; // R7
          pe_pull_out[gi] <= 1'b0;
        end else begin
          pe_pin_out[gi] <= fo[gi];
          pe_pin_oe_out[gi] <= fe[gi];
          // pulls only on pull-capable pins that are not driven
          pe_pull_out[gi] <= pull_q[`PEPFC_B_PE] && pull_mask[gi] && !fe[gi]; // R13 R14
        end
      end
    end
  endgenerate
endmodule // pepfc_top

//--- common/pepfc_map.vh
// How it works
// R1 - pipe enable drives PE6:5 queue status
// R2 - protected bits write once or skip-first
// R3 - e_clock disable writable per single-chip mode
// R4 - E pin input only in peripheral
// R5 - PE4 carries E clock unless disabled
// R6 - PE3 low strobe when enabled, mode-gated
// R7 - narrow expanded: PE3 high output at reset
// R8 - sample PE3 at E fall for tag
// R9 - PE2 read/write in expanded modes (not single-chip or peripheral) when enabled
// R10 - calibration enable free, selects PE7 function
// R11 - PE7 data enable or inverted E
// R12 - select bit ignored single-chip/peripheral
// R13 - pulls only on inputs; regs hidden peripheral
// R14 - port E pulls only PE7, PE3:0
// R15 - A/B pulls off while bus used
// R16 - G/H pull devices follow enable
// R17 - low drive per port, all outputs
// R18 - data-enable disable bit governs PE7
// R19 - normal expanded reset: only data enable, E
// R20 - write-once flag for the assignment and reduced drive registers
`ifndef PEPFC_MAP_VH
`define PEPFC_MAP_VH
// ==========================================
// register byte offsets
`define PEPFC_ADDR_ASGN 4'h0
`define PEPFC_ADDR_PULL 4'h4
`define PEPFC_ADDR_RDRV 4'h8
`define PEPFC_ADDR_CTRL 4'hC
// ==========================================
// assignment register bits
`define PEPFC_B_DENDIS 7
`define PEPFC_B_CGMT 6
`define PEPFC_B_PIPE 5
`define PEPFC_B_NECK 4
`define PEPFC_B_LSTR 3
`define PEPFC_B_RWEN 2
`define PEPFC_B_CALEN 1
`define PEPFC_B_SEL 0
// pull register bits
`define PEPFC_B_PH 7
`define PEPFC_B_PG 6
`define PEPFC_B_PE 4
`define PEPFC_B_PB 1
`define PEPFC_B_PA 0
// ==========================================
// mode codes
`define PEPFC_M_NSC 3'h0
`define PEPFC_M_NEXN 3'h1
`define PEPFC_M_NEXW 3'h2
`define PEPFC_M_PER 3'h3
`define PEPFC_M_SSC 3'h4
`define PEPFC_M_SEXN 3'h5
`define PEPFC_M_SEXW 3'h6
// ==========================================
// reset values by mode
`define PEPFC_RST_NEX 8'h00
`define PEPFC_RST_SEX 8'h2C
`define PEPFC_RST_PER 8'hD0
`define PEPFC_RST_NSC 8'h90
`define PEPFC_RST_SSC 8'h2C
`define PEPFC_RST_PULL 8'hD3
`define PEPFC_RST_RDRV 8'h00
`define PEPFC_RST_PIN_LVL 8'h08
`define PEPFC_RST_PIN_OE 8'h08
`define PEPFC_PULL_E_MASK 8'h8F
`define PEPFC_RESP_OK 2'h0
`define PEPFC_RESP_ERR 2'h2
`endif

//--- tb/pepfc_pin_partner.sv
`timescale 1ns/10ps
// ==========
// pin side model
module pepfc_pin_partner (
  input wire logic clk_in, // clock
  input wire logic tag_low_in, // hold PE3 low
  input wire logic [7:0] drv_in, // device levels
  input wire logic [7:0] oe_in, // device enables
  input wire logic [7:0] pull_in, // device pull-ups
  output logic [7:0] pins_out // pin levels
);
  logic flip_q = 1'b0;
  // undriven pins without pull-up wander so no stale level passes
  always @(posedge clk_in) flip_q <= ~flip_q;
  always @* begin
    pins_out = (oe_in & drv_in) | (~oe_in & (pull_in | {8{flip_q}}));
    if (tag_low_in) pins_out[3] = 1'b0;
  end
endmodule // pepfc_pin_partner

//--- tb/pepfc_props_properties.sv
`timescale 1ns/10ps
`include "pepfc_map.vh"
// ==========
// port checks
module pepfc_props (
  input wire clk_sys_in, // clock
  input wire rst_in, // reset
  input wire [2:0] mode_in, // mode
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire [31:0] s_axi_rdata, // r data
  input wire [7:0] pe_pin_out, // levels
  input wire [7:0] pe_pin_oe_out, // enables
  input wire [7:0] pe_pull_out, // pulls
  input wire e_clock_is_input_out, // E input
  input wire low_byte_tag_out, // tag
  input wire [4:0] pull_active_out // port pulls
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  e_dir_a: assert property (!$past(rst_in) |-> e_clock_is_input_out == ($past(mode_in) == `PEPFC_M_PER))
    else $error("E pin direction wrong");
  e_per_a: assert property (mode_in == `PEPFC_M_PER |=> !pe_pin_oe_out[4])
    else $error("E pin driven in peripheral");
  strobe_high_a: assert property (mode_in == `PEPFC_M_NEXN |=> pe_pin_oe_out[3] && pe_pin_out[3])
    else $error("strobe pin not high output");
  pull_e_a: assert property (pe_pull_out[6:4] == 3'h0)
    else $error("pull on PE6 to PE4");
  pull_input_a: assert property ((pe_pull_out & pe_pin_oe_out) == 8'h00)
    else $error("pull on driven pin");
  pull_ab_a: assert property (mode_in != `PEPFC_M_NSC && mode_in != `PEPFC_M_SSC
    |=> pull_active_out[1:0] == 2'h0)
    else $error("bus port pull active");
  tag_mode_a: assert property (low_byte_tag_out |-> mode_in == `PEPFC_M_SEXN
    || mode_in == `PEPFC_M_SEXW)
    else $error("tag outside special expanded");
  tag_pulse_a: assert property (low_byte_tag_out |=> !low_byte_tag_out)
    else $error("tag longer than a cycle");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cover property (low_byte_tag_out);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (mode_in == `PEPFC_M_PER ##1 e_clock_is_input_out);
endmodule // pepfc_props
bind pepfc_top pepfc_props u_props (.clk_sys_in, .rst_in, .mode_in, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pe_pin_out, .pe_pin_oe_out,
  .pe_pull_out, .e_clock_is_input_out, .low_byte_tag_out, .pull_active_out);

//--- tb/tb.sv
`timescale 1ns/10ps
`include "pepfc_map.vh"
// ==========
// bench
module tb;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, e_stretch_ctrl_in = 1'b0, debug_tagging_in = 1'b0;
  logic e_clock_pin_in = 1'b0, clock_test_in = 1'b0, low_byte_strobe_in = 1'b1;
  logic bus_read_in = 1'b0, data_bus_enable_n_in = 1'b0, cal_ref_in = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, e_run = 1'b0, tag_low = 1'b0;
  logic [1:0] pipe_status_in = 2'h0, r;
  logic [2:0] mode_in = 3'h0, e_cnt = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [4:0] port_dir_any_in = 5'h00;
  logic [7:0] pe_gpio_out_in = 8'h00, pe_gpio_dir_in = 8'h00;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, d;
  wire e_clock_in, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire low_byte_tag_out, e_clock_is_input_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [4:0] pull_active_out, low_drive_out;
  wire [7:0] pe_pin_in, pe_pin_out, pe_pin_oe_out, pe_pull_out;
  wire [31:0] s_axi_rdata;
  integer failures = 0, comparisons = 0, cyc = 0, tag_n = 0;
  pepfc_top u_dut (.*);
  pepfc_pin_partner u_pins (.clk_in(clk_sys_in), .tag_low_in(tag_low), .drv_in(pe_pin_out),
    .oe_in(pe_pin_oe_out), .pull_in(pe_pull_out), .pins_out(pe_pin_in));
  assign e_clock_in = e_cnt[2];
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    if (e_run) e_cnt <= e_cnt + 3'h1;
    if (low_byte_tag_out === 1'b1) tag_n <= tag_n + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      final_report;
    end
  end
  task final_report;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic nclk(input integer n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic rst_mode(input logic [2:0] m);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    mode_in <= m;
    nclk(4);
    rst_in <= 1'b0;
    nclk(2);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      r = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk_sys_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic reset_values;
    logic [55:0] tbl = {`PEPFC_RST_SEX, `PEPFC_RST_SEX, `PEPFC_RST_SSC, `PEPFC_RST_PER,
      `PEPFC_RST_NEX, `PEPFC_RST_NEX, `PEPFC_RST_NSC};
    for (int m = 0; m < 7; m++) begin
      rst_mode(m[2:0]);
      chk(e_clock_is_input_out, m == 3);
      rd(`PEPFC_ADDR_ASGN);
      if (m == 3) chk(r, `PEPFC_RESP_ERR);
      else chk(d, tbl[m*8 +: 8]);
      rd(`PEPFC_ADDR_RDRV);
      chk(r, (m == 3) ? `PEPFC_RESP_ERR : `PEPFC_RESP_OK);
    end
  endtask
  task automatic bus_pins;
    rst_mode(`PEPFC_M_NEXW);
    chk({pe_pin_oe_out[7:2], pe_pin_out[7]}, 7'h48);
    wr(`PEPFC_ADDR_ASGN, 32'hEF);
    rd(`PEPFC_ADDR_ASGN);
    chk(d, 32'hAF);
    wr(`PEPFC_ADDR_ASGN, 32'h00);
    rd(`PEPFC_ADDR_ASGN);
    chk(d, 32'hAD);
    wr(`PEPFC_ADDR_ASGN, 32'h02);
    rd(`PEPFC_ADDR_ASGN);
    chk(d, 32'hAF);
    wr(`PEPFC_ADDR_RDRV, 32'h13);
    wr(`PEPFC_ADDR_RDRV, 32'h00);
    rd(`PEPFC_ADDR_RDRV);
    chk(d, 32'h13);
    chk(low_drive_out, 5'h07);
    cal_ref_in <= 1'b1;
    pipe_status_in <= 2'h3;
    low_byte_strobe_in <= 1'b0;
    bus_read_in <= 1'b1;
    nclk(3);
    chk({pe_pin_oe_out[7:2], pe_pin_out[7:2]}, 12'hFF9);
  endtask
  task automatic narrow_strobe;
    rst_mode(`PEPFC_M_NEXN);
    chk({pe_pin_oe_out[3], pe_pin_out[3]}, 2'h3);
    wr(`PEPFC_ADDR_ASGN, 32'h08);
    nclk(3);
    chk({pe_pin_oe_out[3], pe_pin_out[3]}, 2'h3);
    rd(32'h10);
    chk(r, `PEPFC_RESP_ERR);
    wr(32'h10, 32'h00);
    chk(r, `PEPFC_RESP_ERR);
  endtask
  task automatic pulls;
    rst_mode(`PEPFC_M_NSC);
    port_dir_any_in <= 5'h01;
    pe_gpio_dir_in <= 8'h04;
    nclk(3);
    chk(pull_active_out, 5'h1E);
    chk(pe_pull_out, 8'h8B);
    wr(`PEPFC_ADDR_PULL, 32'h00);
    nclk(3);
    chk(pull_active_out, 5'h00);
  endtask
  task automatic tagging;
    integer base;
    rst_mode(`PEPFC_M_SEXN);
    wr(`PEPFC_ADDR_ASGN, 32'h01);
    rd(`PEPFC_ADDR_ASGN);
    chk(d, 32'h2C);
    wr(`PEPFC_ADDR_ASGN, 32'h0B);
    rd(`PEPFC_ADDR_ASGN);
    chk(d, 32'h0B);
    debug_tagging_in <= 1'b1;
    tag_low <= 1'b1;
    e_run <= 1'b1;
    nclk(40);
    chk(tag_n != 0, 1);
    debug_tagging_in <= 1'b0;
    nclk(3);
    base = tag_n;
    nclk(40);
    chk(tag_n - base, 0);
  endtask
  initial begin
    reset_values;
    bus_pins;
    narrow_strobe;
    pulls;
    tagging;
    final_report;
  end
endmodule // tb
